/* File: src/scu_top.sv */
// System control unit: clock selection, power modes, peripheral gating,
// reset generation with cause record, system interrupts and device info.
// Assumes all inputs synchronous to mclk; oscillator ticks are one-cycle pulses.
//
// Notes on behaviour
// - System clock from one of five sources.
// - PLL reference from any oscillator source.
// - Internal oscillator monitors main oscillator, PLL.
// - ADC clock comes from running PLL.
// - PWM clock divides by powers of two.
// - Sleep stops only processor clock when gating is off.
// - Deep sleep stops processor and PLL.
// - Enabled interrupt wakes to run mode.
// - Low-power modes entered only on request.
// - Five events generate a system reset.
// - Reset causes accumulate and are readable.
// - Per-peripheral clock enable and reset.
// - Separate enable sets for sleep, deep sleep.
// - Seven system interrupt sources.
// - Sources enabled singly, held until cleared.
// - Read-only memory, peripheral, pin info.
// - Regulator 2.25 to 2.75 V, default 2.5 V.
// - ADC rate reads back as one of four.
// - Brown-out optional resample after delay.
// - Disabling the active oscillator is ignored.
`timescale 1ns/1ps

module scu_top #(
	parameter logic [31:0] MEM_INFO = 32'h0000_0000, // Arbitrary value.
	parameter logic [31:0] PER_INFO = 32'h0000_0000, // Arbitrary value.
	parameter logic [31:0] PIN_INFO = 32'h0000_0000 // Arbitrary value.
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire scu_pkg::scu_bus_s bus,
	output logic [31:0] rd_data,
	input wire logic int_osc_tick,
	input wire logic main_osc_tick,
	input wire logic pll_tick,
	input wire logic pll_locked,
	input wire logic ldo_ilim,
	input wire logic bor_det,
	input wire logic ldo_low,
	input wire logic ext_rst_req,
	input wire logic wdt_timeout,
	input wire logic periph_irq,
	output logic [2:0] sysclk_sel,
	output logic [1:0] pll_ref_sel,
	output logic pll_pwr_en,
	output logic main_osc_en,
	output logic int_osc_en,
	output logic adc_clk_en,
	output logic [1:0] adc_speed,
	output logic pwm_clk_en,
	output logic cpu_clk_en,
	output logic [31:0] periph_clk_en,
	output logic [31:0] periph_rst,
	output logic [3:0] ldo_vsel,
	output logic sys_rst_b,
	output logic irq
);

	// ************************************************************
	// State and helpers.
	// ************************************************************
	scu_pkg::scu_state_s s_reg; // Registered state.
	scu_pkg::scu_state_s s_next; // Next state.

	// True when oscillator code o feeds the system clock, directly or through the PLL selected as system clock.
	function automatic logic osc_used(input logic [2:0] sel, input logic [1:0] pref,
		input logic [2:0] o);
		osc_used = (sel == o) || (sel == scu_pkg::SRC_PLL && {1'b0, pref} == o);
	endfunction

	// ************************************************************
	// Next-state logic.
	// ************************************************************
	// All behaviour lives in this one process so each flag has one writer.
	always_comb begin
		logic [6:0] ev; // Interrupt events this cycle.
		logic [5:0] rc; // Reset causes this cycle.
		logic wake;
		logic bor_ev;
		ev = '0;
		rc = '0;
		bor_ev = 1'b0;
		wake = 1'b0;
		s_next = s_reg;
		s_next.rdata = '0;

		// Read data stands only in the cycle after the strobe.
		if (bus.rd) begin
			unique case (bus.addr)
				scu_pkg::OFF_CLK_CFG: s_next.rdata = 32'({s_reg.gate, s_reg.pver, s_reg.mver,
					s_reg.iver, s_reg.adc_spd, s_reg.pwm_div, s_reg.pwm_exp, s_reg.iosc_dis,
					s_reg.mosc_dis, s_reg.pll_pd, s_reg.pref, s_reg.src});
				scu_pkg::OFF_LDO: s_next.rdata = 32'(s_reg.ldo);
				scu_pkg::OFF_RUN_EN: s_next.rdata = s_reg.run_en;
				scu_pkg::OFF_SLP_EN: s_next.rdata = s_reg.slp_en;
				scu_pkg::OFF_DSL_EN: s_next.rdata = s_reg.dsl_en;
				scu_pkg::OFF_PRST: s_next.rdata = s_reg.prst;
				scu_pkg::OFF_INT_RAW: s_next.rdata = 32'(s_reg.int_raw);
				scu_pkg::OFF_INT_EN: s_next.rdata = 32'(s_reg.int_en);
				scu_pkg::OFF_INT_MSK: s_next.rdata = 32'(s_reg.int_raw & s_reg.int_en);
				scu_pkg::OFF_CAUSE: s_next.rdata = 32'(s_reg.cause);
				scu_pkg::OFF_BOR: s_next.rdata = 32'({s_reg.bor_dly, s_reg.ldo_rst,
					s_reg.bor_resamp, s_reg.bor_rst});
				scu_pkg::OFF_MEM_INFO: s_next.rdata = MEM_INFO;
				scu_pkg::OFF_PER_INFO: s_next.rdata = PER_INFO;
				scu_pkg::OFF_PIN_INFO: s_next.rdata = PIN_INFO;
				scu_pkg::OFF_STATUS: s_next.rdata = 32'({s_reg.sel, pll_locked, s_reg.mode});
				default: s_next.rdata = '0;
			endcase
		end

		// Register writes.
		if (bus.wr) begin
			unique case (bus.addr)
				scu_pkg::OFF_CLK_CFG: begin
					// Source codes above the PLL are not sources; keep the old one.
					if (bus.wdata[scu_pkg::CFG_SRC +: 3] <= scu_pkg::SRC_PLL) begin
						s_next.src = bus.wdata[scu_pkg::CFG_SRC +: 3];
					end
					s_next.pref = bus.wdata[scu_pkg::CFG_PREF +: 2];
					s_next.pll_pd = bus.wdata[scu_pkg::CFG_PLL_PD];
					// A disable of an oscillator in use is dropped, judged on the new setting.
					s_next.mosc_dis = bus.wdata[scu_pkg::CFG_MOSC_DIS] &&
						!osc_used(s_next.src, s_next.pref, scu_pkg::SRC_MAIN);
					s_next.iosc_dis = bus.wdata[scu_pkg::CFG_IOSC_DIS] &&
						!osc_used(s_next.src, s_next.pref, scu_pkg::SRC_INT) &&
						!osc_used(s_next.src, s_next.pref, scu_pkg::SRC_INT4);
					if (bus.wdata[scu_pkg::CFG_PWM_EXP +: 3] <= scu_pkg::PWM_EXP_MAX) begin
						s_next.pwm_exp = bus.wdata[scu_pkg::CFG_PWM_EXP +: 3];
					end
					s_next.pwm_div = bus.wdata[scu_pkg::CFG_PWM_DIV];
					s_next.adc_spd = bus.wdata[scu_pkg::CFG_ADC_SPD +: 2];
					s_next.iver = bus.wdata[scu_pkg::CFG_IVER];
					s_next.mver = bus.wdata[scu_pkg::CFG_MVER];
					s_next.pver = bus.wdata[scu_pkg::CFG_PVER];
					s_next.gate = bus.wdata[scu_pkg::CFG_GATE];
				end
				scu_pkg::OFF_LDO: begin
					// Codes beyond 2.75 V would overstress the core; they are ignored.
					if (bus.wdata[3:0] <= scu_pkg::LDO_MAX) begin
						s_next.ldo = bus.wdata[3:0];
					end
				end
				scu_pkg::OFF_RUN_EN: s_next.run_en = bus.wdata;
				scu_pkg::OFF_SLP_EN: s_next.slp_en = bus.wdata;
				scu_pkg::OFF_DSL_EN: s_next.dsl_en = bus.wdata;
				scu_pkg::OFF_PRST: s_next.prst = bus.wdata;
				scu_pkg::OFF_INT_RAW: s_next.int_raw = s_reg.int_raw & ~bus.wdata[6:0];
				scu_pkg::OFF_INT_EN: s_next.int_en = bus.wdata[6:0];
				scu_pkg::OFF_CAUSE: s_next.cause = s_reg.cause & ~bus.wdata[5:0];
				scu_pkg::OFF_SLEEP: begin
					// Only software asks for a low-power mode, and only from run.
					if (s_reg.mode == scu_pkg::SCU_RUN) begin
						if (bus.wdata[scu_pkg::SLP_DEEP]) begin
							s_next.mode = scu_pkg::SCU_DEEP;
						end else if (bus.wdata[scu_pkg::SLP_SLEEP]) begin
							s_next.mode = scu_pkg::SCU_SLEEP;
						end
					end
				end
				scu_pkg::OFF_SWRST: rc[scu_pkg::RC_SW] = bus.wdata[0];
				scu_pkg::OFF_BOR: begin
					s_next.bor_rst = bus.wdata[scu_pkg::BOR_RST];
					s_next.bor_resamp = bus.wdata[scu_pkg::BOR_RESAMP];
					s_next.ldo_rst = bus.wdata[scu_pkg::BOR_LDO_RST];
					s_next.bor_dly = bus.wdata[scu_pkg::BOR_DLY +: 13];
				end
				default: begin
					// Unmapped and read-only words take no write.
				end
			endcase
		end

		// PWM divider: a one-cycle enable every 2^exp system cycles.
		if (!s_reg.pwm_div || s_reg.pwm_cnt == 6'((7'h01 << s_reg.pwm_exp) - 7'h01)) begin
			s_next.pwm_cnt = '0;
			s_next.pwm_tick = 1'b1;
		end else begin
			s_next.pwm_cnt = s_reg.pwm_cnt + 6'h01;
			s_next.pwm_tick = 1'b0;
		end

		// Internal oscillator watched by mclk; the others by internal ticks.
		if (int_osc_tick || !s_reg.iver || s_reg.iosc_dis) begin
			s_next.iosc_cnt = '0;
		end else if (s_reg.iosc_cnt == scu_pkg::IOSC_CYC - 10'h001) begin
			ev[scu_pkg::INT_IOSC_FAIL] = 1'b1;
			s_next.iosc_cnt = '0;
		end else begin
			s_next.iosc_cnt = s_reg.iosc_cnt + 10'h001;
		end
		if (main_osc_tick || !s_reg.mver || s_reg.mosc_dis) begin
			s_next.mosc_cnt = '0;
		end else if (int_osc_tick) begin
			if (s_reg.mosc_cnt == scu_pkg::MON_TICKS - 5'h01) begin
				ev[scu_pkg::INT_MOSC_FAIL] = 1'b1;
				s_next.mosc_cnt = '0;
			end else begin
				s_next.mosc_cnt = s_reg.mosc_cnt + 5'h01;
			end
		end
		if (pll_tick || !s_reg.pver || !pll_pwr_en) begin
			s_next.pll_cnt = '0;
		end else if (int_osc_tick) begin
			if (s_reg.pll_cnt == scu_pkg::MON_TICKS - 5'h01) begin
				ev[scu_pkg::INT_PLL_FAIL] = 1'b1;
				s_next.pll_cnt = '0;
			end else begin
				s_next.pll_cnt = s_reg.pll_cnt + 5'h01;
			end
		end

		// Brown-out sampled on internal oscillator ticks, optionally twice.
		if (int_osc_tick) begin
			if (s_reg.bor_wait) begin
				if (s_reg.bor_cnt == '0) begin
					bor_ev = bor_det;
					s_next.bor_wait = 1'b0;
				end else begin
					s_next.bor_cnt = s_reg.bor_cnt - 13'h0001;
				end
			end else if (bor_det) begin
				if (s_reg.bor_resamp) begin
					s_next.bor_wait = 1'b1;
					s_next.bor_cnt = s_reg.bor_dly;
				end else begin
					bor_ev = 1'b1;
				end
			end
		end

		// Interrupt events.
		s_next.lock_q = pll_locked;
		ev[scu_pkg::INT_PLL_LOCK] = pll_locked && !s_reg.lock_q;
		ev[scu_pkg::INT_ILIM] = ldo_ilim;
		ev[scu_pkg::INT_BOR] = bor_ev;
		ev[scu_pkg::INT_LDO_LOW] = ldo_low;
		s_next.int_raw = s_next.int_raw | ev;

		// Reset events.
		rc[scu_pkg::RC_EXT] = ext_rst_req;
		rc[scu_pkg::RC_BOR] = bor_ev && s_reg.bor_rst;
		rc[scu_pkg::RC_LDO] = ldo_low && s_reg.ldo_rst;
		rc[scu_pkg::RC_WDT] = wdt_timeout;

		// Any enabled interrupt wakes the processor.
		wake = (|(s_reg.int_raw & s_reg.int_en)) || periph_irq;
		if (s_reg.mode != scu_pkg::SCU_RUN && wake) begin
			s_next.mode = scu_pkg::SCU_RUN;
		end

		// Active source: deep sleep drops the PLL for its reference oscillator.
		if (s_next.mode == scu_pkg::SCU_DEEP && s_next.src == scu_pkg::SRC_PLL) begin
			s_next.sel = {1'b0, s_next.pref};
		end else begin
			s_next.sel = s_next.src;
		end

		// System reset restores defaults but keeps and adds to the cause record, less the power-on bit.
		if (|rc) begin
			s_next = scu_pkg::STATE_RST;
			s_next.cause = (s_reg.cause & ~scu_pkg::CAUSE_RST) | rc;
			s_next.lock_q = pll_locked;
			s_next.rst_cnt = scu_pkg::RST_CYC;
		end else if (s_reg.rst_cnt != '0) begin
			s_next.rst_cnt = s_reg.rst_cnt - 7'h01;
		end
	end

	// ************************************************************
	// State register.
	// ************************************************************
	// Power-on reset is the only asynchronous reset of this unit; it records itself.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= scu_pkg::STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ************************************************************
	// Outputs.
	// ************************************************************
	assign rd_data = s_reg.rdata;
	assign sysclk_sel = s_reg.sel;
	assign pll_ref_sel = s_reg.pref;
	assign pll_pwr_en = !s_reg.pll_pd && s_reg.mode != scu_pkg::SCU_DEEP;
	assign main_osc_en = !s_reg.mosc_dis;
	assign int_osc_en = !s_reg.iosc_dis;
	assign adc_clk_en = pll_pwr_en && pll_locked;
	assign adc_speed = s_reg.adc_spd;
	assign pwm_clk_en = s_reg.pwm_tick;
	assign cpu_clk_en = s_reg.mode == scu_pkg::SCU_RUN;
	// Without gating every run-enabled peripheral keeps running in sleep.
	assign periph_clk_en = (s_reg.mode == scu_pkg::SCU_RUN || !s_reg.gate) ? s_reg.run_en :
		(s_reg.mode == scu_pkg::SCU_SLEEP) ? s_reg.slp_en : s_reg.dsl_en;
	assign periph_rst = s_reg.prst;
	assign ldo_vsel = s_reg.ldo;
	assign sys_rst_b = s_reg.rst_cnt == '0;
	assign irq = |(s_reg.int_raw & s_reg.int_en);

	// ************************************************************
	// Assertions.
	// ************************************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// In sleep the processor stays stopped and the clock selection may not move.
	sleep_no_cpu_a: assert property (s_reg.mode == scu_pkg::SCU_SLEEP &&
		$past(s_reg.mode) == scu_pkg::SCU_SLEEP |-> !cpu_clk_en &&
		$stable(sysclk_sel) && $stable(pll_pwr_en))
		else $error("processor clocked or clocks changed in sleep");
	deep_no_pll_a: assert property (s_reg.mode == scu_pkg::SCU_DEEP |->
		!cpu_clk_en && !pll_pwr_en && sysclk_sel != scu_pkg::SRC_PLL)
		else $error("PLL used in deep sleep");
	wake_on_irq_a: assert property (s_reg.mode != scu_pkg::SCU_RUN && irq |=> cpu_clk_en)
		else $error("enabled interrupt did not wake");
	sleep_on_req_a: assert property ($rose(s_reg.mode != scu_pkg::SCU_RUN) |->
		$past(bus.wr) && $past(bus.addr) == scu_pkg::OFF_SLEEP)
		else $error("low-power mode without a request");
	ldo_range_a: assert property (ldo_vsel <= scu_pkg::LDO_MAX)
		else $error("regulator code out of range");
	// Any reset event of the same cycle restarts the unit, which may drop the source.
	pending_hold_a: assert property (s_reg.int_raw[scu_pkg::INT_BOR] && sys_rst_b &&
		!(bus.wr && bus.addr == scu_pkg::OFF_INT_RAW) &&
		!(bus.wr && bus.addr == scu_pkg::OFF_SWRST) &&
		!ext_rst_req && !wdt_timeout && !bor_det && !ldo_low
		|=> s_reg.int_raw[scu_pkg::INT_BOR])
		else $error("pending source lost without clear");
	sw_reset_a: assert property (bus.wr && bus.addr == scu_pkg::OFF_SWRST &&
		bus.wdata[0] |=> !sys_rst_b && s_reg.cause[scu_pkg::RC_SW] ##1 !sys_rst_b [*8])
		else $error("software reset not generated");
	wdt_reset_a: assert property (wdt_timeout |=> s_reg.cause[scu_pkg::RC_WDT])
		else $error("watchdog cause not recorded");
	active_osc_a: assert property (osc_used(sysclk_sel, pll_ref_sel,
		scu_pkg::SRC_MAIN) |-> main_osc_en)
		else $error("active main oscillator disabled");
	masked_line_a: assert property (irq == |(s_reg.int_raw & s_reg.int_en))
		else $error("interrupt line not the masked OR");
	pwm_div_a: assert property (pwm_clk_en && s_reg.pwm_div &&
		s_reg.pwm_exp == 3'h1 && !(bus.wr && bus.addr == scu_pkg::OFF_CLK_CFG) && sys_rst_b
		|=> !pwm_clk_en ##1 pwm_clk_en)
		else $error("PWM divide by two wrong");

endmodule

/* File: src/scu_pkg.sv */
// Package of the system control unit: offsets, field positions, reset values,
// timing counts and the types that carry its state.
// Assumes a 100 MHz mclk and a plain one-cycle register port.
package scu_pkg;

	// ************************************************************
	// Register offsets (byte addresses, one 32-bit word each).
	// ************************************************************
	localparam logic [7:0] OFF_CLK_CFG = 8'h00; // Clock source, PLL, PWM, ADC, monitors.
	localparam logic [7:0] OFF_LDO = 8'h04; // Regulator voltage code.
	localparam logic [7:0] OFF_RUN_EN = 8'h08; // Peripheral clock enables in run mode.
	localparam logic [7:0] OFF_SLP_EN = 8'h0c; // Peripheral clock enables in sleep mode.
	localparam logic [7:0] OFF_DSL_EN = 8'h10; // Peripheral clock enables in deep sleep.
	localparam logic [7:0] OFF_PRST = 8'h14; // Peripheral resets, held while set.
	localparam logic [7:0] OFF_INT_RAW = 8'h18; // Raw pending sources, write one to clear.
	localparam logic [7:0] OFF_INT_EN = 8'h1c; // Interrupt source enables.
	localparam logic [7:0] OFF_INT_MSK = 8'h20; // Pending sources gated by enables.
	localparam logic [7:0] OFF_CAUSE = 8'h24; // Reset causes, write one to clear.
	localparam logic [7:0] OFF_SLEEP = 8'h28; // Low-power request.
	localparam logic [7:0] OFF_SWRST = 8'h2c; // Software reset request.
	localparam logic [7:0] OFF_BOR = 8'h30; // Brown-out configuration.
	localparam logic [7:0] OFF_MEM_INFO = 8'h34; // Memory sizes, read only.
	localparam logic [7:0] OFF_PER_INFO = 8'h38; // Peripherals present, read only.
	localparam logic [7:0] OFF_PIN_INFO = 8'h3c; // Pins present, read only.
	localparam logic [7:0] OFF_STATUS = 8'h40; // Mode, lock and active source.

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int CFG_SRC = 0; // Three bits of system clock source.
	localparam int CFG_PREF = 3; // Two bits of PLL reference source.
	localparam int CFG_PLL_PD = 5; // PLL powered down.
	localparam int CFG_MOSC_DIS = 6; // Main oscillator disable.
	localparam int CFG_IOSC_DIS = 7; // Internal oscillator disable.
	localparam int CFG_PWM_EXP = 8; // Three bits of PWM divide exponent.
	localparam int CFG_PWM_DIV = 11; // PWM divider in use.
	localparam int CFG_ADC_SPD = 12; // Two bits of ADC sample rate.
	localparam int CFG_IVER = 14; // Internal oscillator monitor enable.
	localparam int CFG_MVER = 15; // Main oscillator monitor enable.
	localparam int CFG_PVER = 16; // PLL monitor enable.
	localparam int CFG_GATE = 17; // Sleep gating uses the sleep enable sets.
	localparam int BOR_RST = 0; // Brown-out causes reset, else interrupt.
	localparam int BOR_RESAMP = 1; // Brown-out must hold on two samples.
	localparam int BOR_LDO_RST = 2; // Regulator low causes reset.
	localparam int BOR_DLY = 3; // Thirteen bits of resample delay.
	localparam int SLP_SLEEP = 0; // Request sleep.
	localparam int SLP_DEEP = 1; // Request deep sleep.

	// Interrupt source bits.
	localparam int INT_PLL_LOCK = 0;
	localparam int INT_ILIM = 1;
	localparam int INT_IOSC_FAIL = 2;
	localparam int INT_MOSC_FAIL = 3;
	localparam int INT_BOR = 4;
	localparam int INT_LDO_LOW = 5;
	localparam int INT_PLL_FAIL = 6;

	// Reset cause bits.
	localparam int RC_POR = 0;
	localparam int RC_EXT = 1;
	localparam int RC_BOR = 2;
	localparam int RC_LDO = 3;
	localparam int RC_SW = 4;
	localparam int RC_WDT = 5;

	// ************************************************************
	// Encodings, reset values and timing.
	// ************************************************************
	localparam logic [2:0] SRC_EXT = 3'h0;
	localparam logic [2:0] SRC_MAIN = 3'h1;
	localparam logic [2:0] SRC_INT = 3'h2;
	localparam logic [2:0] SRC_INT4 = 3'h3;
	localparam logic [2:0] SRC_PLL = 3'h4;
	localparam logic [2:0] SRC_RST = SRC_MAIN;
	localparam logic [1:0] PREF_RST = 2'h1; // Main oscillator.
	localparam logic [3:0] LDO_MAX = 4'ha; // 2.75 V, steps of 50 mV from 2.25 V.
	localparam logic [3:0] LDO_RST = 4'h5; // 2.5 V.
	localparam logic [2:0] PWM_EXP_MAX = 3'h6; // Divide by 64.
	localparam logic [5:0] CAUSE_RST = 6'h01; // Power-on recorded.
	localparam int RST_HOLD_NS = 1000; // Least length of the system reset.
	localparam int CLK_NS = 10;
	localparam logic [6:0] RST_CYC = 7'((RST_HOLD_NS + CLK_NS - 1) / CLK_NS);
	localparam int IOSC_WIN_NS = 10000; // Longest gap between internal ticks.
	localparam logic [9:0] IOSC_CYC = 10'(IOSC_WIN_NS / CLK_NS);
	localparam logic [4:0] MON_TICKS = 5'h10; // Internal ticks allowed without a tick.

	typedef enum logic [1:0] {
		SCU_RUN = 2'b00,
		SCU_SLEEP = 2'b01,
		SCU_DEEP = 2'b10
	} scu_mode_e;

	// Whole state of the unit.
	typedef struct packed {
		logic [31:0] rdata;
		logic [2:0] src;
		logic [1:0] pref;
		logic pll_pd;
		logic mosc_dis;
		logic iosc_dis;
		logic [2:0] pwm_exp;
		logic pwm_div;
		logic [1:0] adc_spd;
		logic iver;
		logic mver;
		logic pver;
		logic gate;
		logic [3:0] ldo;
		logic [31:0] run_en;
		logic [31:0] slp_en;
		logic [31:0] dsl_en;
		logic [31:0] prst;
		logic [6:0] int_raw;
		logic [6:0] int_en;
		logic [5:0] cause;
		scu_mode_e mode;
		logic bor_rst;
		logic bor_resamp;
		logic ldo_rst;
		logic [12:0] bor_dly;
		logic [12:0] bor_cnt;
		logic bor_wait;
		logic [5:0] pwm_cnt;
		logic pwm_tick;
		logic [9:0] iosc_cnt;
		logic [4:0] mosc_cnt;
		logic [4:0] pll_cnt;
		logic lock_q;
		logic [6:0] rst_cnt;
		logic [2:0] sel;
	} scu_state_s;

	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} scu_bus_s;

	localparam scu_state_s STATE_RST = '{src: SRC_RST, pref: PREF_RST, ldo: LDO_RST,
		cause: CAUSE_RST, mode: SCU_RUN, sel: SRC_RST, default: '0};

endpackage

/* File: bench/scu_osc_model.sv */
// Stand-in for the oscillators and the PLL that sit around the system control unit.
// Assumes one mclk domain; every tick is a one-cycle pulse, one in four cycles.
`timescale 1ns/1ps
module scu_osc_model #(
	parameter int LOCK_CYC = 20 // Powered cycles before the PLL reports lock.
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic pll_pwr_en,
	input wire logic main_stop,
	output logic int_osc_tick,
	output logic main_osc_tick,
	output logic pll_tick,
	output logic pll_locked
);
	logic [1:0] div_reg; // Free phase counter shared by all ticks.
	int lock_cnt; // Powered cycles seen since the PLL was last switched on.
	// Main ticks pause only while main_stop is high, so the monitor can be tripped.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end
	assign int_osc_tick = (div_reg == 2'h0);
	assign main_osc_tick = !main_stop && (div_reg == 2'h1);
	assign pll_tick = pll_pwr_en && (div_reg == 2'h2);
	// Lock is lost at once when power goes, as a real loop would.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lock_cnt <= 0;
		end else if (!pll_pwr_en) begin
			lock_cnt <= 0;
		end else if (lock_cnt < LOCK_CYC) begin
			lock_cnt <= lock_cnt + 1;
		end
	end
	assign pll_locked = pll_pwr_en && (lock_cnt == LOCK_CYC);
endmodule

/* File: bench/system_control_unit_test.sv */
// Self-checking bench of the system control unit, driven over its register port.
// Assumes the oscillator stand-in in scu_osc_model.sv and a 100 MHz mclk.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module system_control_unit_test;
	// ************************************************************
	// Stimulus, observed outputs and the design.
	// ************************************************************
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	scu_pkg::scu_bus_s bus = '0;
	logic ldo_ilim = 1'b0, bor_det = 1'b0, ldo_low = 1'b0;
	logic ext_rst_req = 1'b0, wdt_timeout = 1'b0, periph_irq = 1'b0, main_stop = 1'b0;
	logic [31:0] rd_data, periph_clk_en, periph_rst;
	logic [2:0] sysclk_sel;
	logic [1:0] pll_ref_sel, adc_speed;
	logic [3:0] ldo_vsel;
	logic pll_pwr_en, main_osc_en, int_osc_en, adc_clk_en, pwm_clk_en, cpu_clk_en;
	logic sys_rst_b, irq, int_osc_tick, main_osc_tick, pll_tick, pll_locked;
	int n_fail = 0, compares = 0, cyc = 0, n;
	always #5 mclk = ~mclk;
	scu_top #(.MEM_INFO(32'h1234_5678), .PER_INFO(32'h0000_00ff)) u_dut (.mclk, .rst_b, .bus,
		.rd_data, .int_osc_tick, .main_osc_tick, .pll_tick, .pll_locked, .ldo_ilim, .bor_det,
		.ldo_low, .ext_rst_req, .wdt_timeout, .periph_irq, .sysclk_sel, .pll_ref_sel,
		.pll_pwr_en, .main_osc_en, .int_osc_en, .adc_clk_en, .adc_speed, .pwm_clk_en,
		.cpu_clk_en, .periph_clk_en, .periph_rst, .ldo_vsel, .sys_rst_b, .irq);
	scu_osc_model u_osc (.mclk, .rst_b, .pll_pwr_en, .int_osc_tick, .main_osc_tick,
		.pll_tick, .pll_locked, .main_stop);
	// ************************************************************
	// Bus tasks; each leaves 1 ns after the edge that took the request.
	// ************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe, so compare there.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		`CHK(rd_data, e)
	endtask
	// Counts cycles of system reset, bounded so a stuck reset cannot hang the run.
	task automatic sysrst(output int lo);
		lo = 0;
		while (sys_rst_b !== 1'b1 && lo < 300) begin
			@(posedge mclk);
			#1;
			lo++;
		end
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// A hang counts as a mismatch; the tests need about 2000 cycles.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// ************************************************************
	// Test sequence.
	// ************************************************************
	initial begin
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (30) @(posedge mclk);
		rd(scu_pkg::OFF_CAUSE, 32'h1);
		rd(scu_pkg::OFF_CLK_CFG, 32'h9);
		// Source 5 does not exist and main is in use, so neither field may change.
		wr(scu_pkg::OFF_CLK_CFG, 32'h4d);
		rd(scu_pkg::OFF_CLK_CFG, 32'h9);
		`CHK(main_osc_en, 1'b1)
		for (int k = 0; k < 5; k++) begin
			wr(scu_pkg::OFF_CLK_CFG, {27'h0, 2'(k), 3'(k)});
			`CHK(sysclk_sel, 3'(k))
			`CHK(pll_ref_sel, 2'(k))
		end
		wr(scu_pkg::OFF_CLK_CFG, 32'h92);
		`CHK(int_osc_en, 1'b1)
		for (int k = 0; k < 4; k++) begin
			wr(scu_pkg::OFF_CLK_CFG, {18'h0, 2'(k), 12'h009});
			`CHK(adc_speed, 2'(k))
			`CHK(adc_clk_en, 1'b1)
		end
		rd(scu_pkg::OFF_CLK_CFG, 32'h3009);
		wr(scu_pkg::OFF_LDO, 32'ha);
		wr(scu_pkg::OFF_LDO, 32'hb);
		rd(scu_pkg::OFF_LDO, 32'ha);
		`CHK(ldo_vsel, 4'ha)
		wr(scu_pkg::OFF_PER_INFO, 32'hffff_ffff);
		rd(scu_pkg::OFF_PER_INFO, 32'h0000_00ff);
		rd(scu_pkg::OFF_MEM_INFO, 32'h1234_5678);
		rd(8'h80, 32'h0);
		done("config");
		// Every divide exponent: after settling, 128 cycles hold 128 >> k pulses.
		for (int k = 0; k < 7; k++) begin
			wr(scu_pkg::OFF_CLK_CFG, {20'h0, 1'b1, 3'(k), 8'h09});
			repeat (64) @(posedge mclk);
			n = 0;
			repeat (128) begin
				@(posedge mclk);
				#1;
				n += (pwm_clk_en === 1'b1);
			end
			`CHK(n, 128 >> k)
		end
		done("pwm");
		wr(scu_pkg::OFF_INT_RAW, 32'h7f);
		@(posedge mclk);
		ldo_ilim <= 1'b1;
		@(posedge mclk);
		ldo_ilim <= 1'b0;
		rd(scu_pkg::OFF_INT_RAW, 32'h2);
		`CHK(irq, 1'b0)
		wr(scu_pkg::OFF_INT_EN, 32'h2);
		`CHK(irq, 1'b1)
		rd(scu_pkg::OFF_INT_MSK, 32'h2);
		wr(scu_pkg::OFF_INT_RAW, 32'h2);
		`CHK(irq, 1'b0)
		done("interrupt");
		wr(scu_pkg::OFF_RUN_EN, 32'ha5a5_0f0f);
		`CHK(periph_clk_en, 32'ha5a5_0f0f)
		wr(scu_pkg::OFF_PRST, 32'h3);
		`CHK(periph_rst, 32'h3)
		wr(scu_pkg::OFF_SLP_EN, 32'h1);
		wr(scu_pkg::OFF_DSL_EN, 32'h2);
		wr(scu_pkg::OFF_CLK_CFG, 32'h2_000c);
		wr(scu_pkg::OFF_SLEEP, 32'h1);
		`CHK(cpu_clk_en, 1'b0)
		`CHK(sysclk_sel, 3'h4)
		`CHK(periph_clk_en, 32'h1)
		repeat (8) @(posedge mclk);
		#1;
		`CHK(cpu_clk_en, 1'b0)
		@(posedge mclk);
		periph_irq <= 1'b1;
		@(posedge mclk);
		periph_irq <= 1'b0;
		#1;
		`CHK(cpu_clk_en, 1'b1)
		wr(scu_pkg::OFF_SLEEP, 32'h2);
		`CHK(pll_pwr_en, 1'b0)
		`CHK(sysclk_sel, 3'h1)
		`CHK(periph_clk_en, 32'h2)
		rd(scu_pkg::OFF_STATUS, 32'ha);
		// The enabled current-limit source must wake the core from deep sleep.
		@(posedge mclk);
		ldo_ilim <= 1'b1;
		@(posedge mclk);
		ldo_ilim <= 1'b0;
		@(posedge mclk);
		#1;
		`CHK(cpu_clk_en, 1'b1)
		`CHK(periph_clk_en, 32'ha5a5_0f0f)
		done("sleep");
		wr(scu_pkg::OFF_SWRST, 32'h1);
		sysrst(n);
		`CHK(n, int'(scu_pkg::RST_CYC))
		rd(scu_pkg::OFF_CAUSE, 32'h10);
		rd(scu_pkg::OFF_LDO, 32'h5);
		@(posedge mclk);
		wdt_timeout <= 1'b1;
		@(posedge mclk);
		wdt_timeout <= 1'b0;
		#1;
		sysrst(n);
		@(posedge mclk);
		ext_rst_req <= 1'b1;
		@(posedge mclk);
		ext_rst_req <= 1'b0;
		#1;
		sysrst(n);
		rd(scu_pkg::OFF_CAUSE, 32'h32);
		wr(scu_pkg::OFF_CAUSE, 32'h10);
		rd(scu_pkg::OFF_CAUSE, 32'h22);
		done("reset");
		// Brown-out set to interrupt, and regulator low, both seen on the raw status.
		wr(scu_pkg::OFF_INT_RAW, 32'h7f);
		@(posedge mclk);
		bor_det <= 1'b1;
		ldo_low <= 1'b1;
		repeat (12) @(posedge mclk);
		bor_det <= 1'b0;
		ldo_low <= 1'b0;
		rd(scu_pkg::OFF_INT_RAW, 32'h30);
		// With resampling, a short dip is forgiven and a lasting one is reported.
		wr(scu_pkg::OFF_BOR, 32'h1a);
		rd(scu_pkg::OFF_BOR, 32'h1a);
		wr(scu_pkg::OFF_INT_RAW, 32'h7f);
		@(posedge mclk);
		bor_det <= 1'b1;
		repeat (8) @(posedge mclk);
		bor_det <= 1'b0;
		repeat (20) @(posedge mclk);
		rd(scu_pkg::OFF_INT_RAW, 32'h0);
		@(posedge mclk);
		bor_det <= 1'b1;
		repeat (24) @(posedge mclk);
		bor_det <= 1'b0;
		rd(scu_pkg::OFF_INT_RAW, 32'h10);
		done("brownout");
		// Running main ticks keep the monitor quiet; stopped ones raise its source.
		wr(scu_pkg::OFF_CLK_CFG, 32'h8009);
		wr(scu_pkg::OFF_INT_RAW, 32'h7f);
		repeat (80) @(posedge mclk);
		rd(scu_pkg::OFF_INT_RAW, 32'h0);
		@(posedge mclk);
		main_stop <= 1'b1;
		repeat (70) @(posedge mclk);
		main_stop <= 1'b0;
		rd(scu_pkg::OFF_INT_RAW, 32'h8);
		done("monitor");
		tally_and_finish();
	end
endmodule
